/* File: src/spv_pkg.sv */
// Package for the port state-variable and reset/init block
//
// Behaviour
// [R01] Signature refresh flag set at reset or reset request, cleared by signature FIS.
// [R02] Sixteen shadow busy bits cleared at reset; entry 0 drives status busy without switching.
// [R03] Sixteen shadow DRQ bits cleared at reset; entry 0 drives status DRQ without switching.
// [R04] Next issue device cleared to zero at reset.
// [R05] Port-mux id of last received FIS held, reset zero.
// [R06] Per-device last issued slot, reset to 32; entry 0 only without switching.
// [R07] Per-device data transfer slot, reset zero; entry 0 only without switching.
// [R08] Port-mux id of last sent command FIS held, reset zero.
// [R09] Packet pending set on ATAPI issue, cleared when packet Data FIS sent.
// [R10] Per-device PIO flag set when PIO Setup FIS arrives for that device.
// [R11] PIO Setup end status, error and interrupt bit held until block done.
// [R12] DMA count loaded per transfer, decremented by each good Data FIS.
// [R13] DMA count zero means lengths come from PRD table only.
// [R14] Command send pending until fetched command is sent, reset zero.
// [R15] Per-device PRD done flag raises PRD interrupt at end of good data FIS.
// [R16] SActive of received Set Device Bits FIS copied, reset zero.
// [R17] Slot scan pointer names next issue slot, reset zero.
// [R18] Reset state entered asynchronously at power-up and at the next clock on global reset rise.
// [R19] Reset state waits for global controller to leave init.
// [R20] Init restores all variables and port register fields except base addresses.
// [R21] Init clears busy 0, sets DRQ 0, loads status 7f, sets signature refresh.
// [R22] Init sends COMRESET when spin-up requested, then goes to stopped state.
// [R23] With cold presence support, port power stays off until software enables it.
// [R24] Per-device arrays indexed by 4-bit port-mux id.
package spv_pkg;
  localparam int                      NUM_DEV        = 16;
  localparam logic [5:0]              SLOT_RESET     = 6'h20;
  localparam logic [7:0]              TFD_INIT_STS   = 8'h7f;
  localparam int                      STS_BSY_BIT    = 7;
  localparam int                      STS_DRQ_BIT    = 3;

  typedef enum logic [1:0] {SPV_RESET, SPV_INIT, SPV_STOPPED} spv_state_t;

  // Received FIS events from the link layer
  typedef struct packed {
    logic        sig_fis;       // D2H register FIS carrying signature
    logic        pio_setup;     // PIO Setup FIS
    logic        sdb;           // Set Device Bits FIS
    logic        data_ok;       // Data FIS received good
    logic [3:0]  pmp;
    logic [7:0]  end_status;
    logic [7:0]  error;
    logic        irq_bit;
    logic [31:0] sactive;
    logic [15:0] data_len;
  } spv_rx_t;

  // Transmit-side and issue events
  typedef struct packed {
    logic        issue;         // command issued
    logic        atapi;         // issued command had the ATAPI bit
    logic [3:0]  dev;           // target device of issued command
    logic [4:0]  slot;
    logic        cmd_fetched;
    logic        cmd_sent;
    logic        packet_sent;   // Data FIS with packet command sent
    logic [3:0]  cmd_pmp;       // PMP field from command table
    logic        dma_load;
    logic [31:0] dma_count;
    logic        data_slot_load;
    logic        prd_done;
    logic        pio_block_done;
    logic        sig_reset_req; // hard or software reset needs new signature
    logic [4:0]  next_slot;
    logic        slot_adv;
  } spv_ev_t;

  typedef struct packed {
    spv_state_t        state;
    logic              hr_prev;
    logic              sig_refresh_pending;
    logic [15:0]       dev_busy_shadow;
    logic [15:0]       dev_drq_shadow;
    logic [3:0]        next_issue_device;
    logic [3:0]        last_rx_portmux_id;
    logic [15:0][5:0]  last_issued_slot;
    logic [15:0][4:0]  data_xfer_slot;
    logic [3:0]        last_tx_portmux_id;
    logic              packet_cmd_pending;
    logic [15:0]       pio_xfer_flag;
    logic [7:0]        pio_end_status_hold;
    logic [7:0]        pio_error_hold;
    logic              pio_irq_bit_hold;
    logic [31:0]       dma_remaining_count;
    logic              cmd_send_pending;
    logic [15:0]       prd_done_flag;
    logic [31:0]       active_tag_copy;
    logic [4:0]        slot_scan_pointer;
    logic [7:0]        taskfile_status;
    logic              comreset;
    logic              port_power;
    logic              prd_irq;
  } spv_st_t;
endpackage : spv_pkg

/* File: src/spv_port_vars.sv */
// Port state variables with reset and init sequencing
module spv_port_vars (
  input  wire logic            CLK_IN,
  input  wire logic            RESET_N_IN,
  input  wire logic            GLOBAL_HBA_RESET_BIT_IN,
  input  wire logic            HBA_IN_INIT_IN,
  input  wire logic            FIS_SWITCH_ENABLE_IN,
  input  wire logic            SPIN_UP_REQUEST_IN,
  input  wire logic            COLD_PRESENCE_SUPPORT_IN,
  input  wire logic            POWER_ENABLE_IN,
  input  wire spv_pkg::spv_rx_t RX_IN,
  input  wire spv_pkg::spv_ev_t EV_IN,
  output logic                 PORT_STOPPED_STATE_OUT,
  output logic                 IN_INIT_OUT,
  output logic                 REG_FIELD_RESET_OUT,
  output logic                 COMRESET_OUT,
  output logic                 PORT_POWER_OUT,
  output logic [7:0]           TASKFILE_STATUS_OUT,
  output logic                 SIG_REFRESH_PENDING_OUT,
  output logic                 PACKET_CMD_PENDING_OUT,
  output logic                 CMD_SEND_PENDING_OUT,
  output logic [31:0]          DMA_REMAINING_COUNT_OUT,
  output logic                 PRD_ONLY_LENGTH_OUT,
  output logic [31:0]          ACTIVE_TAG_COPY_OUT,
  output logic [4:0]           SLOT_SCAN_POINTER_OUT,
  output logic [3:0]           NEXT_ISSUE_DEVICE_OUT,
  output logic [3:0]           LAST_RX_PORTMUX_ID_OUT,
  output logic [3:0]           LAST_TX_PORTMUX_ID_OUT,
  output logic [7:0]           PIO_END_STATUS_HOLD_OUT,
  output logic [7:0]           PIO_ERROR_HOLD_OUT,
  output logic                 PIO_IRQ_BIT_HOLD_OUT,
  output logic                 PRD_IRQ_OUT,
  output logic [15:0]          PIO_XFER_FLAG_OUT,
  output logic [5:0]           LAST_ISSUED_SLOT_DEV0_OUT,
  output logic [4:0]           DATA_XFER_SLOT_DEV0_OUT
);
  spv_pkg::spv_st_t st_reg;
  spv_pkg::spv_st_t st_next;
  logic [3:0]       rx_idx;
  logic [3:0]       iss_idx;
  logic             hr_rise;

  // Without switching every event lands in entry 0
  assign rx_idx  = FIS_SWITCH_ENABLE_IN ? RX_IN.pmp : 4'h0;  // [R24]
  assign iss_idx = FIS_SWITCH_ENABLE_IN ? EV_IN.dev : 4'h0;  // [R24]
  assign hr_rise = GLOBAL_HBA_RESET_BIT_IN && !st_reg.hr_prev;

  // Next-state logic for the whole variable set
  always_comb
  begin
    st_next          = st_reg;
    st_next.hr_prev  = GLOBAL_HBA_RESET_BIT_IN;
    st_next.comreset = 1'b0;
    st_next.prd_irq  = 1'b0;
    if (hr_rise)
    begin
      st_next.state = spv_pkg::SPV_RESET;  // [R18]
    end
    else
    begin
      unique case (st_reg.state)
        spv_pkg::SPV_RESET:
        begin
          if (!HBA_IN_INIT_IN)
          begin
            st_next.state = spv_pkg::SPV_INIT;  // [R19]
          end
        end
        spv_pkg::SPV_INIT:
        begin
          // Variables go back to their reset values; DRQ 0, status and power take their init values
          st_next.sig_refresh_pending = 1'b1;                     // [R20] [R21]
          st_next.dev_busy_shadow     = '0;                       // [R02] [R21]
          st_next.dev_drq_shadow      = 16'h0001;                 // [R03] [R21]
          st_next.next_issue_device   = '0;                       // [R04]
          st_next.last_rx_portmux_id  = '0;                       // [R05]
          for (int i = 0; i < spv_pkg::NUM_DEV; i++)
          begin
            st_next.last_issued_slot[i] = spv_pkg::SLOT_RESET;    // [R06]
            st_next.data_xfer_slot[i]   = '0;                     // [R07]
          end
          st_next.last_tx_portmux_id  = '0;                       // [R08]
          st_next.packet_cmd_pending  = 1'b0;                     // [R09]
          st_next.pio_xfer_flag       = '0;                       // [R10]
          st_next.pio_end_status_hold = '0;                       // [R11]
          st_next.pio_error_hold      = '0;
          st_next.pio_irq_bit_hold    = 1'b0;
          st_next.dma_remaining_count = '0;                       // [R12]
          st_next.cmd_send_pending    = 1'b0;                     // [R14]
          st_next.prd_done_flag       = '0;                       // [R15]
          st_next.active_tag_copy     = '0;                       // [R16]
          st_next.slot_scan_pointer   = '0;                       // [R17]
          st_next.taskfile_status     = spv_pkg::TFD_INIT_STS;    // [R21]
          st_next.comreset            = SPIN_UP_REQUEST_IN;       // [R22]
          // Power only stays on when presence detect is absent
          st_next.port_power          = !COLD_PRESENCE_SUPPORT_IN; // [R23]
          st_next.state               = spv_pkg::SPV_STOPPED;     // [R22]
        end
        spv_pkg::SPV_STOPPED:
        begin
          // Power is switched on only by software when cold presence is supported
          if (POWER_ENABLE_IN)
          begin
            st_next.port_power = 1'b1;  // [R23]
          end
          // Clears first so a same-cycle set wins
          if (RX_IN.sig_fis)
          begin
            st_next.sig_refresh_pending = 1'b0;  // [R01]
          end
          if (EV_IN.sig_reset_req)
          begin
            st_next.sig_refresh_pending = 1'b1;  // [R01]
          end
          if (RX_IN.sig_fis || RX_IN.pio_setup || RX_IN.sdb || RX_IN.data_ok)
          begin
            st_next.last_rx_portmux_id = RX_IN.pmp;  // [R05]
          end
          if (RX_IN.pio_setup)
          begin
            st_next.pio_xfer_flag[rx_idx] = 1'b1;           // [R10]
            st_next.pio_end_status_hold   = RX_IN.end_status; // [R11]
            st_next.pio_error_hold        = RX_IN.error;
            st_next.pio_irq_bit_hold      = RX_IN.irq_bit;
          end
          // Block done applies the held end status to the shadow status
          if (EV_IN.pio_block_done && !RX_IN.pio_setup)
          begin
            st_next.pio_xfer_flag[rx_idx] = 1'b0;
            st_next.taskfile_status       = st_reg.pio_end_status_hold;  // [R11]
            st_next.dev_busy_shadow[rx_idx] = st_reg.pio_end_status_hold[spv_pkg::STS_BSY_BIT];
            st_next.dev_drq_shadow[rx_idx]  = st_reg.pio_end_status_hold[spv_pkg::STS_DRQ_BIT];
          end
          if (RX_IN.sdb)
          begin
            st_next.active_tag_copy = RX_IN.sactive;  // [R16]
          end
          // Load beats decrement; count saturates at zero
          if (EV_IN.dma_load)
          begin
            st_next.dma_remaining_count = EV_IN.dma_count;  // [R12]
          end
          else if (RX_IN.data_ok)
          begin
            st_next.dma_remaining_count = (st_reg.dma_remaining_count > 32'(RX_IN.data_len))
              ? st_reg.dma_remaining_count - 32'(RX_IN.data_len) : 32'h0;  // [R12]
          end
          if (EV_IN.issue)
          begin
            st_next.next_issue_device          = EV_IN.dev;           // [R04]
            st_next.last_issued_slot[iss_idx]  = {1'b0, EV_IN.slot};  // [R06]
          end
          if (EV_IN.data_slot_load)
          begin
            st_next.data_xfer_slot[iss_idx] = EV_IN.slot;  // [R07]
          end
          if (EV_IN.cmd_sent)
          begin
            st_next.last_tx_portmux_id = EV_IN.cmd_pmp;  // [R08]
            st_next.cmd_send_pending   = 1'b0;           // [R14]
          end
          if (EV_IN.cmd_fetched)
          begin
            st_next.cmd_send_pending = 1'b1;  // [R14]
          end
          if (EV_IN.packet_sent)
          begin
            st_next.packet_cmd_pending = 1'b0;  // [R09]
          end
          if (EV_IN.issue && EV_IN.atapi)
          begin
            st_next.packet_cmd_pending = 1'b1;  // [R09]
          end
          // PRD interrupt fires at the end of a good data FIS
          if (RX_IN.data_ok && st_reg.prd_done_flag[rx_idx])
          begin
            st_next.prd_irq               = 1'b1;  // [R15]
            st_next.prd_done_flag[rx_idx] = 1'b0;
          end
          if (EV_IN.prd_done)
          begin
            st_next.prd_done_flag[rx_idx] = 1'b1;  // [R15]
          end
          if (EV_IN.slot_adv)
          begin
            st_next.slot_scan_pointer = EV_IN.next_slot;  // [R17]
          end
          // Entry 0 mirrors into the status register without switching
          if (!FIS_SWITCH_ENABLE_IN && !EV_IN.pio_block_done)
          begin
            st_next.taskfile_status[spv_pkg::STS_BSY_BIT] = st_next.dev_busy_shadow[0];  // [R02]
            st_next.taskfile_status[spv_pkg::STS_DRQ_BIT] = st_next.dev_drq_shadow[0];   // [R03]
          end
        end
        default:
        begin
          st_next.state = spv_pkg::SPV_RESET;
        end
      endcase
    end
  end

  // State register; power-up lands in the reset state
  always_ff @(posedge CLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      st_reg                     <= '0;
      st_reg.state               <= spv_pkg::SPV_RESET;  // [R18]
      st_reg.sig_refresh_pending <= 1'b1;                // [R01]
      for (int i = 0; i < spv_pkg::NUM_DEV; i++)
      begin
        st_reg.last_issued_slot[i] <= spv_pkg::SLOT_RESET;  // [R06]
      end
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign PORT_STOPPED_STATE_OUT    = (st_reg.state == spv_pkg::SPV_STOPPED);
  assign IN_INIT_OUT               = (st_reg.state == spv_pkg::SPV_INIT);
  assign REG_FIELD_RESET_OUT       = (st_reg.state == spv_pkg::SPV_INIT);  // [R20]
  assign COMRESET_OUT              = st_reg.comreset;
  assign PORT_POWER_OUT            = st_reg.port_power;
  assign TASKFILE_STATUS_OUT       = st_reg.taskfile_status;
  assign SIG_REFRESH_PENDING_OUT   = st_reg.sig_refresh_pending;
  assign PACKET_CMD_PENDING_OUT    = st_reg.packet_cmd_pending;
  assign CMD_SEND_PENDING_OUT      = st_reg.cmd_send_pending;
  assign DMA_REMAINING_COUNT_OUT   = st_reg.dma_remaining_count;
  assign PRD_ONLY_LENGTH_OUT       = (st_reg.dma_remaining_count == 32'h0);  // [R13]
  assign ACTIVE_TAG_COPY_OUT       = st_reg.active_tag_copy;
  assign SLOT_SCAN_POINTER_OUT     = st_reg.slot_scan_pointer;
  assign NEXT_ISSUE_DEVICE_OUT     = st_reg.next_issue_device;
  assign LAST_RX_PORTMUX_ID_OUT    = st_reg.last_rx_portmux_id;
  assign LAST_TX_PORTMUX_ID_OUT    = st_reg.last_tx_portmux_id;
  assign PIO_END_STATUS_HOLD_OUT   = st_reg.pio_end_status_hold;
  assign PIO_ERROR_HOLD_OUT        = st_reg.pio_error_hold;
  assign PIO_IRQ_BIT_HOLD_OUT      = st_reg.pio_irq_bit_hold;
  assign PRD_IRQ_OUT               = st_reg.prd_irq;
  assign PIO_XFER_FLAG_OUT         = st_reg.pio_xfer_flag;
  assign LAST_ISSUED_SLOT_DEV0_OUT = st_reg.last_issued_slot[0];
  assign DATA_XFER_SLOT_DEV0_OUT   = st_reg.data_xfer_slot[0];

  // Checks on reset and init sequencing; a global reset rise overrides every other arc
  init_seq_a: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)  // [R21]
    (IN_INIT_OUT && !hr_rise)
      |=> PORT_STOPPED_STATE_OUT && TASKFILE_STATUS_OUT == spv_pkg::TFD_INIT_STS && SIG_REFRESH_PENDING_OUT)
    else $error("init did not load status and flags");
  reset_wait_a: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)  // [R19]
    (st_reg.state == spv_pkg::SPV_RESET && HBA_IN_INIT_IN && !hr_rise) |=> !IN_INIT_OUT)
    else $error("left reset while controller in init");
  hr_rise_a: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)  // [R18]
    $rose(GLOBAL_HBA_RESET_BIT_IN) |=> !PORT_STOPPED_STATE_OUT && !IN_INIT_OUT)
    else $error("global reset rise did not enter reset");
  comreset_a: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)  // [R22]
    (IN_INIT_OUT && SPIN_UP_REQUEST_IN && !hr_rise) |=> COMRESET_OUT)
    else $error("no COMRESET with spin-up");
  power_off_a: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)  // [R23]
    (IN_INIT_OUT && COLD_PRESENCE_SUPPORT_IN && !hr_rise) |=> !PORT_POWER_OUT)
    else $error("power on after init with cold presence");

  // Checks on the issue and transmit side
  dma_load_a: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)  // [R12] [R13]
    (PORT_STOPPED_STATE_OUT && EV_IN.dma_load && !hr_rise)
      |=> DMA_REMAINING_COUNT_OUT == $past(EV_IN.dma_count)
        && PRD_ONLY_LENGTH_OUT == ($past(EV_IN.dma_count) == 32'h0))
    else $error("DMA count load or PRD-only indication wrong");
  atapi_set_a: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)  // [R09]
    (PORT_STOPPED_STATE_OUT && EV_IN.issue && EV_IN.atapi && !hr_rise) |=> PACKET_CMD_PENDING_OUT)
    else $error("packet pending not set");
  issue_dev_a: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)  // [R04]
    (PORT_STOPPED_STATE_OUT && EV_IN.issue && !hr_rise) |=> NEXT_ISSUE_DEVICE_OUT == $past(EV_IN.dev))
    else $error("next issue device not recorded");
  sig_set_a: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)  // [R01]
    (PORT_STOPPED_STATE_OUT && EV_IN.sig_reset_req && !hr_rise) |=> SIG_REFRESH_PENDING_OUT)
    else $error("signature refresh lost");
  busy_mirror_a: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)  // [R02]
    (PORT_STOPPED_STATE_OUT && !FIS_SWITCH_ENABLE_IN && !EV_IN.pio_block_done && !hr_rise)
      |=> TASKFILE_STATUS_OUT[7] == st_reg.dev_busy_shadow[0])
    else $error("busy mirror broken");
  pend_set_a: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)  // [R14]
    (PORT_STOPPED_STATE_OUT && EV_IN.cmd_fetched && !hr_rise) |=> CMD_SEND_PENDING_OUT)
    else $error("send pending not set");

  // Checks on the receive side; holdings must carry the fields of the FIS just taken
  pio_hold_a: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)  // [R10] [R11]
    (PORT_STOPPED_STATE_OUT && RX_IN.pio_setup && !hr_rise)
      |=> PIO_END_STATUS_HOLD_OUT == $past(RX_IN.end_status) && PIO_ERROR_HOLD_OUT == $past(RX_IN.error)
        && PIO_IRQ_BIT_HOLD_OUT == $past(RX_IN.irq_bit) && PIO_XFER_FLAG_OUT[$past(rx_idx)])
    else $error("PIO setup fields not held");
  sdb_copy_a: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)  // [R16]
    (PORT_STOPPED_STATE_OUT && RX_IN.sdb && !hr_rise) |=> ACTIVE_TAG_COPY_OUT == $past(RX_IN.sactive))
    else $error("active tag copy not taken");
  prd_irq_a: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)  // [R15]
    (PORT_STOPPED_STATE_OUT && RX_IN.data_ok && st_reg.prd_done_flag[rx_idx] && !hr_rise) |=> PRD_IRQ_OUT)
    else $error("PRD interrupt missing");

  // Main scenarios
  init_cov_c:   cover property (@(posedge CLK_IN) IN_INIT_OUT ##1 PORT_STOPPED_STATE_OUT);
  comres_cov_c: cover property (@(posedge CLK_IN) COMRESET_OUT);
  prd_cov_c:    cover property (@(posedge CLK_IN) PRD_IRQ_OUT);
  pio_cov_c:    cover property (@(posedge CLK_IN) RX_IN.pio_setup ##[1:20] EV_IN.pio_block_done);
  hr_cov_c:     cover property (@(posedge CLK_IN) hr_rise ##1 !PORT_STOPPED_STATE_OUT);
endmodule : spv_port_vars

/* File: dv/spv_link_model.sv */
// Link-side drive model: queues FISes toward the port and answers COMRESET with a signature FIS
module spv_link_model #(
  parameter int RESP_DLY = 4
) (
  input  wire logic        clk_in,
  input  wire logic        comreset_in,
  output spv_pkg::spv_rx_t rx_out
);
  timeunit 1ns;
  timeprecision 1ns;

  spv_pkg::spv_rx_t q[$];
  logic [95:0]      junk;
  int               junk_seed = 42614;

  // Idle cycles keep strobes low but put fresh garbage in the fields, so stale data is never trusted
  always @(negedge clk_in)
  begin
    junk = {$random(junk_seed), $random(junk_seed), $random(junk_seed)};
    if (q.size() > 0)
      rx_out <= q.pop_front();
    else
      rx_out <= {4'h0, junk[68:0]};
  end

  // The drive answers a COMRESET with its signature FIS after a settable delay
  always @(negedge clk_in)
  begin
    if (comreset_in === 1'b1)
    begin
      repeat (RESP_DLY) @(posedge clk_in);
      q.push_back({4'b1000, 69'h0});
    end
  end

  // Queued at a rising edge so the drive process picks it up without a race
  task automatic send(input spv_pkg::spv_rx_t f);
    @(posedge clk_in);
    q.push_back(f);
    repeat (2) @(negedge clk_in);
  endtask
endmodule // spv_link_model

/* File: dv/tb_top.sv */
// Self-checking bench for the port state variables and the reset/init sequence
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk = 1'b0, rst_n = 1'b0, hr = 1'b0, hinit = 1'b1, fsw = 1'b0, spin = 1'b1, cpd = 1'b1, pwr = 1'b0;
  spv_pkg::spv_rx_t rx;
  spv_pkg::spv_ev_t ev = '0;
  logic stp, ini, rfr, cmr, ppw, sig, pkt, cmd, prdo, irq, pirq;
  logic [7:0] tfd, psts, perr;
  logic [31:0] dma, tags;
  logic [4:0] sptr, dslot;
  logic [3:0] ndev, rpmp, tpmp;
  logic [15:0] pflg;
  logic [5:0] islot;
  int errors = 0;
  int n_checks = 0;
  int seed = 42614;

  // Half period of 25 ns gives the 20 MHz clock
  always #25 clk = ~clk;

  spv_port_vars spv_port_vars_inst (
    .CLK_IN(clk), .RESET_N_IN(rst_n), .GLOBAL_HBA_RESET_BIT_IN(hr), .HBA_IN_INIT_IN(hinit),
    .FIS_SWITCH_ENABLE_IN(fsw), .SPIN_UP_REQUEST_IN(spin), .COLD_PRESENCE_SUPPORT_IN(cpd),
    .POWER_ENABLE_IN(pwr), .RX_IN(rx), .EV_IN(ev), .PORT_STOPPED_STATE_OUT(stp), .IN_INIT_OUT(ini),
    .REG_FIELD_RESET_OUT(rfr), .COMRESET_OUT(cmr), .PORT_POWER_OUT(ppw), .TASKFILE_STATUS_OUT(tfd),
    .SIG_REFRESH_PENDING_OUT(sig), .PACKET_CMD_PENDING_OUT(pkt), .CMD_SEND_PENDING_OUT(cmd),
    .DMA_REMAINING_COUNT_OUT(dma), .PRD_ONLY_LENGTH_OUT(prdo), .ACTIVE_TAG_COPY_OUT(tags),
    .SLOT_SCAN_POINTER_OUT(sptr), .NEXT_ISSUE_DEVICE_OUT(ndev), .LAST_RX_PORTMUX_ID_OUT(rpmp),
    .LAST_TX_PORTMUX_ID_OUT(tpmp), .PIO_END_STATUS_HOLD_OUT(psts), .PIO_ERROR_HOLD_OUT(perr),
    .PIO_IRQ_BIT_HOLD_OUT(pirq), .PRD_IRQ_OUT(irq), .PIO_XFER_FLAG_OUT(pflg),
    .LAST_ISSUED_SLOT_DEV0_OUT(islot), .DATA_XFER_SLOT_DEV0_OUT(dslot));

  spv_link_model #(.RESP_DLY(4)) spv_link_model_inst (.clk_in(clk), .comreset_in(cmr), .rx_out(rx));

  // Verdict and end of run, shared by the main sequence and every bounded wait
  task automatic end_sim();
    if (errors == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e)
    begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // Bounded wait on a flag; running out of cycles counts as a mismatch
  task automatic wait_for(ref logic s, input logic v, input int lim);
    for (int i = 0; i < lim && s !== v; i++) @(negedge clk);
    chk(s, v);
    if (s !== v)
      end_sim();
  endtask

  // One-cycle event pulse; returns once the answering edge has landed
  task automatic send_ev(input spv_pkg::spv_ev_t e);
    @(negedge clk);
    ev = e;
    @(negedge clk);
    ev = '0;
  endtask

  // Count never wraps below zero
  function automatic logic [31:0] dma_after(input logic [31:0] c, input logic [15:0] l);
    return (c > {16'h0, l}) ? c - {16'h0, l} : 32'h0;
  endfunction

  task automatic chk_rst();
    chk(sig, 1);
    chk(ndev, 0);
    chk(rpmp, 0);
    chk(islot, 32);
    chk(dslot, 0);
    chk(tpmp, 0);
    chk(pkt, 0);
    chk(pflg, 0);
    chk({psts, perr, pirq}, 0);
    chk(dma, 0);
    chk(prdo, 1);
    chk(cmd, 0);
    chk(tags, 0);
    chk(sptr, 0);
  endtask

  // Hang guard well above the length of the sequence
  initial
  begin
    repeat (20000) @(posedge clk);
    errors++;
    end_sim();
  end

  // Main sequence: reset, init, random traffic, then a global reset mid-run
  initial
  begin
    spv_pkg::spv_ev_t e;
    spv_pkg::spv_rx_t f;
    logic [31:0] c;
    logic [5:0] s0;
    repeat (20) @(negedge clk);
    chk(stp, 0);
    chk_rst();
    rst_n = 1'b1;
    repeat (5) @(negedge clk);
    chk({stp, ini}, 0);
    hinit = 1'b0;
    @(negedge clk);
    chk({ini, rfr}, 2'h3);
    @(negedge clk);
    chk(stp, 1);
    chk(tfd, spv_pkg::TFD_INIT_STS);
    chk(cmr, spin);
    chk(ppw, 0);
    chk_rst();
    @(negedge clk);
    chk(cmr, 0);
    wait_for(sig, 0, 20);
    e = '0;
    e.sig_reset_req = 1'b1;
    send_ev(e);
    chk(sig, 1);
    pwr = 1'b1;
    wait_for(ppw, 1, 3);
    fsw = 1'b1;
    s0 = spv_pkg::SLOT_RESET;
    // Random traffic with per-device indexing on
    for (int k = 0; k < 8; k++)
    begin
      e = '0;
      e.cmd_fetched = 1'b1;
      send_ev(e);
      chk(cmd, 1);
      e = '0;
      e.cmd_sent = 1'b1;
      e.cmd_pmp = 4'($random(seed));
      send_ev(e);
      chk({cmd, tpmp}, {1'b0, e.cmd_pmp});
      e = '0;
      e.issue = 1'b1;
      e.atapi = k[0];
      e.slot = 5'($random(seed));
      e.dev = k[2] ? 4'($random(seed)) : 4'h0;
      if (e.dev == 4'h0)
        s0 = {1'b0, e.slot};
      send_ev(e);
      chk({pkt, islot, ndev}, {k[0], s0, e.dev});
      e = '0;
      e.packet_sent = 1'b1;
      e.data_slot_load = 1'b1;
      e.slot_adv = 1'b1;
      e.slot = 5'($random(seed));
      e.next_slot = 5'($random(seed));
      send_ev(e);
      chk({pkt, dslot, sptr}, {1'b0, e.slot, e.next_slot});
      c = {15'h0, 17'($random(seed))};
      e = '0;
      e.dma_load = 1'b1;
      e.dma_count = c;
      send_ev(e);
      chk({prdo, dma}, {c == 0, c});
      for (int j = 0; j < 2; j++)
      begin
        f = '0;
        f.data_ok = 1'b1;
        f.pmp = 4'($random(seed));
        f.data_len = 16'($random(seed));
        spv_link_model_inst.send(f);
        c = dma_after(c, f.data_len);
        chk({prdo, dma, rpmp}, {c == 0, c, f.pmp});
      end
      f = '0;
      f.sdb = 1'b1;
      f.sactive = $random(seed);
      spv_link_model_inst.send(f);
      chk(tags, f.sactive);
      f = '0;
      f.pio_setup = 1'b1;
      f.pmp = 4'($random(seed));
      f.end_status = 8'($random(seed));
      f.error = 8'($random(seed));
      f.irq_bit = k[1];
      spv_link_model_inst.send(f);
      chk({psts, perr, pirq, rpmp}, {f.end_status, f.error, k[1], f.pmp});
      chk(pflg[f.pmp], 1);
    end
    // Without switching, the held end status lands in the status register after the block
    fsw = 1'b0;
    f = '0;
    f.pio_setup = 1'b1;
    f.end_status = 8'($random(seed));
    spv_link_model_inst.send(f);
    e = '0;
    e.pio_block_done = 1'b1;
    send_ev(e);
    chk(tfd, f.end_status);
    @(negedge clk);
    chk(tfd, f.end_status);
    e = '0;
    e.prd_done = 1'b1;
    send_ev(e);
    f = '0;
    f.data_ok = 1'b1;
    f.data_len = 16'h4;
    spv_link_model_inst.send(f);
    chk(irq, 1);
    @(negedge clk);
    chk(irq, 0);
    spv_link_model_inst.send(f);
    chk(irq, 0);
    // Global reset rise mid-run with state dirtied first
    e = '0;
    e.cmd_fetched = 1'b1;
    e.dma_load = 1'b1;
    e.dma_count = 32'h40;
    send_ev(e);
    spin = 1'b0;
    pwr = 1'b0;
    hinit = 1'b1;
    hr = 1'b1;
    wait_for(stp, 0, 3);
    repeat (3) @(negedge clk);
    chk({stp, ini}, 0);
    hinit = 1'b0;
    wait_for(stp, 1, 6);
    chk(cmr, 0);
    chk(ppw, 0);
    chk(tfd, spv_pkg::TFD_INIT_STS);
    chk_rst();
    end_sim();
  end
endmodule // tb_top
